// ### tb_watchdog_timeout_control.sv
// Self-checking testbench of the watchdog timeout control block
`timescale 1ns/1ps
module tb_watchdog_timeout_control;
  import watchdog_pkg::*;
  // Small base keeps every timeout short
  localparam logic [21:0] BASE = 22'h000010;
  logic aclk = 0, aresetn = 0, watchdog_osc = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, rnd;
  logic watchdog_reset_req, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [33:0] rd_q[$];
  logic [1:0] wr_q[$];
  int err_count = 0, compares = 0, cyc = 0, osc_cnt = 0, pulses = 0, seed = 22;
  watchdog_timeout_control #(.TIMEOUT_BASE(BASE)) watchdog_timeout_control_inst (
    .aclk(aclk), .aresetn(aresetn), .watchdog_osc(watchdog_osc),
    .watchdog_reset_req(watchdog_reset_req),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  always #25 aclk = ~aclk;
  // ==========================================================================
  // Oscillator at 1 MHz, twenty system cycles a period
  always @(posedge aclk) begin
    osc_cnt <= (osc_cnt == 9) ? 0 : osc_cnt + 1;
    if (osc_cnt == 9) watchdog_osc <= ~watchdog_osc;
  end
  // Hang guard, well above the expected run length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(string what, logic [33:0] seen, logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Outputs judged at the falling edge, where nothing moves
  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      chk("rdata", {s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) chk("bresp", 34'(s_axi_bresp), 34'(wr_q.pop_front()));
    if (watchdog_reset_req === 1'b1) pulses++;
  end
  // ==========================================================================
  // Bus tasks; handshakes captured at the falling edge to dodge races
  // Lag keeps the answer's ready low for that many cycles, so the hold checks see a stall
  task automatic wr(logic [3:0] a, logic [31:0] d, logic [1:0] er = RESP_OKAY, int lag = 0);
    logic ah, wh, bv, bh;
    wr_q.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    do begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      bh = s_axi_bvalid && s_axi_bready;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bv) lag--;
      if (bv && lag == 0) s_axi_bready <= 1'b1;
    end while (!bh);
  endtask : wr
  task automatic rd(logic [3:0] a, logic [31:0] d, logic [1:0] er = RESP_OKAY, int lag = 0);
    logic ah, rv, rh;
    rd_q.push_back({er, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      rh = s_axi_rvalid && s_axi_rready;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
      if (rv) lag--;
      if (rv && lag == 0) s_axi_rready <= 1'b1;
    end while (!rh);
  endtask : rd
  // Interval between two reset requests for one select code
  task automatic period(int sel);
    int n;
    n = 0;
    wr(CTRL_OFFSET, 32'h8 | sel);
    while (watchdog_reset_req !== 1'b1) @(negedge aclk);
    @(negedge aclk);
    while (watchdog_reset_req !== 1'b1) begin
      @(negedge aclk);
      n++;
    end
    chk("interval", 34'(n + 1), 34'(20 * (int'(BASE) << sel)));
    @(posedge aclk);
  endtask : period
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CTRL_OFFSET, 32'h0);
    rd(STATUS_OFFSET, 32'h0);
    rd(4'hc, 32'h0, RESP_DECERR, 2);
    wr(4'hc, 32'h0, RESP_DECERR, 2);
    $display("test reset_map done");
    rnd = $random(seed);
    wr(CTRL_OFFSET, {24'h0, rnd[7:5], 5'h08});
    rd(CTRL_OFFSET, 32'h08);
    wr(CTRL_OFFSET, 32'h00);
    rd(CTRL_OFFSET, 32'h08);
    repeat (4) begin
      repeat (200) @(posedge aclk);
      wr(RESTART_OFFSET, 32'h1);
    end
    chk("pulses", 34'(pulses), 34'h0);
    $display("test lock_restart done");
    // Codes 0, 1, 2 and 4 reach every select bit; 3 skipped to save run time
    for (int s = 0; s < 5; s++) if (s != 3) period(s);
    $display("test timeout done");
    // Back to back with nothing in between, as an uninterrupted sequence must be
    wr(CTRL_OFFSET, 32'h19);
    wr(CTRL_OFFSET, 32'h00);
    rd(CTRL_OFFSET, 32'h00);
    // Byte lane 0 masked: the write must leave the watchdog off
    s_axi_wstrb <= 4'he;
    wr(CTRL_OFFSET, 32'h08);
    s_axi_wstrb <= 4'hf;
    rd(CTRL_OFFSET, 32'h00);
    repeat (4) @(posedge aclk);
    rd(STATUS_OFFSET, 32'h0);
    pulses = 0;
    repeat (800) @(posedge aclk);
    chk("pulses", 34'(pulses), 34'h0);
    wr(CTRL_OFFSET, 32'h08);
    wr(CTRL_OFFSET, 32'h18);
    repeat (6) @(posedge aclk);
    wr(CTRL_OFFSET, 32'h00);
    rd(CTRL_OFFSET, 32'h08);
    $display("test turn_off done");
    final_report();
  end
endmodule : tb_watchdog_timeout_control

// ### timeout_counter.sv
// Watchdog timeout counter advanced by sampled oscillator edges
`timescale 1ns/1ps
module timeout_counter #(
  parameter logic [21:0] TIMEOUT_BASE = watchdog_pkg::TIMEOUT_BASE_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  timeout_if.counter tif
);
  import watchdog_pkg::*;

  logic [COUNT_WIDTH-1:0] count_q;
  logic [COUNT_WIDTH-1:0] limit;
  logic expire_q;
  logic hit;

  // Period doubles with each select code
  assign limit = COUNT_WIDTH'(TIMEOUT_BASE << tif.select); // [RULE_07]
  assign hit = tif.enable && tif.osc_tick && (count_q == limit - 1'b1);

  // ==========================================================================
  // Counter, cleared by reset, restart and while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0; // [RULE_09]
    end else if (!tif.enable || tif.restart || hit) begin
      count_q <= '0; // [RULE_09]
    end else if (tif.osc_tick) begin
      count_q <= count_q + 1'b1; // [RULE_11]
    end
  end

  // Expiry pulse lasts exactly one system clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expire_q <= 1'b0;
    end else begin
      expire_q <= hit && !tif.restart; // [RULE_10]
    end
  end

  assign tif.expire = expire_q;
  assign tif.count = count_q;
endmodule : timeout_counter

// ### timeout_if.sv
// Carrier between the register front end and the timeout counter
`timescale 1ns/1ps
interface timeout_if;
  import watchdog_pkg::*;
  logic enable;
  logic [2:0] select;
  logic restart;
  logic osc_tick;
  logic expire;
  logic [COUNT_WIDTH-1:0] count;

  modport ctrl (output enable, output select, output restart, output osc_tick,
    input expire, input count);
  modport counter (input enable, input select, input restart, input osc_tick,
    output expire, output count);
endinterface : timeout_if

// ### watchdog_pkg.sv
// Constants, register map and field layout of the watchdog timeout control block
// ==========================================================================
// How it works
// [RULE_01] A zero written to the enable bit leaves the watchdog running unless unlock is set.
// [RULE_02] The turn-off unlock bit clears itself four system clock cycles after it is set.
// [RULE_03] Writing one to the enable bit starts the watchdog, a permitted zero stops it.
// [RULE_04] The enable bit can only be cleared while the unlock bit reads as one.
// [RULE_05] Software unlocks by writing ones to unlock and enable in a single write.
// [RULE_06] Software then writes zero to enable within four cycles to turn the watchdog off.
// [RULE_07] Timeout select code 0 gives 16384 oscillator cycles, each code doubles it.
// [RULE_08] Software should keep interrupts away while it runs the turn-off sequence.
// [RULE_09] The counter clears on restart, while disabled and on chip reset.
// [RULE_10] An expiry while enabled gives a system reset pulse of one clock cycle.
// [RULE_11] The counter advances on a separate watchdog oscillator of about 1 MHz.
// [RULE_12] Bits 7 to 5 of the control register always read as zero.
// [RULE_13] Controls and the oscillator are brought safely between the two timing sources.
package watchdog_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] RESTART_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;

  // ==========================================================================
  // Control register fields
  localparam int UNLOCK_BIT = 4;
  localparam int ENABLE_BIT = 3;
  localparam int SELECT_MSB = 2;
  localparam int SELECT_LSB = 0;
  localparam int RESTART_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================================================
  // Timing
  localparam int UNLOCK_WINDOW_CYCLES = 4;
  localparam logic [2:0] UNLOCK_LOAD = 3'(UNLOCK_WINDOW_CYCLES);
  localparam int COUNT_WIDTH = 22;
  localparam int SYNC_STAGES = 2;
  localparam logic [21:0] TIMEOUT_BASE_DEFAULT = 22'h004000;

  // ==========================================================================
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : watchdog_pkg

// ### watchdog_timeout_control.sv
// Watchdog timeout control: AXI4-Lite registers, turn-off unlock and reset request
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module watchdog_timeout_control #(
  parameter logic [21:0] TIMEOUT_BASE = watchdog_pkg::TIMEOUT_BASE_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic watchdog_osc,
  output logic watchdog_reset_req,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import watchdog_pkg::*;

  timeout_if tif ();

  logic aw_held_q;
  logic [3:0] awaddr_q;
  logic w_held_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_write;
  logic ctrl_wr;
  logic restart_wr;
  logic enable_q;
  logic unlock_q;
  logic [2:0] unlock_cnt_q;
  logic [2:0] select_q;
  logic [SYNC_STAGES-1:0] osc_sync_q;
  logic osc_prev_q;
  logic restart_q;
  logic reset_req_q;
  logic [7:0] ctrl_view;

  // ==========================================================================
  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign ctrl_wr = do_write && wstrb0_q && (awaddr_q == CTRL_OFFSET);
  assign restart_wr = do_write && wstrb0_q && (awaddr_q == RESTART_OFFSET)
    && wdata_q[RESTART_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb0_q <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer with a decode error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (awaddr_q == CTRL_OFFSET || awaddr_q == RESTART_OFFSET
        || awaddr_q == STATUS_OFFSET) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ==========================================================================
  // Control register
  // Reserved upper bits are tied low on readback
  assign ctrl_view = {3'h0, unlock_q, enable_q, select_q}; // [RULE_12]

  // Unlock bit: set by a written one, self-clears after the window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock_q <= CTRL_RESET[UNLOCK_BIT];
      unlock_cnt_q <= '0;
    end else if (ctrl_wr && wdata_q[UNLOCK_BIT]) begin
      unlock_q <= 1'b1;
      unlock_cnt_q <= UNLOCK_LOAD - 1'b1; // [RULE_02]
    end else if (unlock_cnt_q != '0) begin
      unlock_cnt_q <= unlock_cnt_q - 1'b1;
    end else begin
      unlock_q <= 1'b0; // [RULE_02]
    end
  end

  // Enable: a one always sets it, a zero only counts while unlocked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= CTRL_RESET[ENABLE_BIT];
    end else if (ctrl_wr) begin
      if (wdata_q[ENABLE_BIT]) begin
        enable_q <= 1'b1; // [RULE_03] [RULE_05]
      end else if (unlock_q) begin
        enable_q <= 1'b0; // [RULE_04] [RULE_06]
      end
      // Otherwise a zero is ignored so stray writes cannot stop it [RULE_01]
    end
  end

  // Timeout select follows every control write with byte lane 0 enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      select_q <= CTRL_RESET[SELECT_MSB:SELECT_LSB];
    end else if (ctrl_wr) begin
      select_q <= wdata_q[SELECT_MSB:SELECT_LSB]; // [RULE_07]
    end
  end

  // Restart strobe, one cycle per accepted restart write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= restart_wr; // [RULE_09]
    end
  end

  // ==========================================================================
  // Oscillator sampling: two flops, edge taken from the second only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_sync_q <= '0;
      osc_prev_q <= 1'b0;
    end else begin
      osc_sync_q <= {osc_sync_q[SYNC_STAGES-2:0], watchdog_osc}; // [RULE_13]
      osc_prev_q <= osc_sync_q[SYNC_STAGES-1];
    end
  end

  // One tick per oscillator rising edge; needs aclk well above osc rate
  assign tif.osc_tick = osc_sync_q[SYNC_STAGES-1] && !osc_prev_q; // [RULE_11]
  assign tif.enable = enable_q;
  assign tif.select = select_q;
  assign tif.restart = restart_q;

  timeout_counter #(
    .TIMEOUT_BASE(TIMEOUT_BASE)
  ) u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .tif(tif)
  );

  // Counter already runs on aclk, so the request needs no further crossing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_req_q <= 1'b0;
    end else begin
      reset_req_q <= tif.expire && enable_q; // [RULE_10] [RULE_13]
    end
  end

  assign watchdog_reset_req = reset_req_q;

  // ==========================================================================
  // AXI4-Lite read path
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      unique case (s_axi_araddr)
        CTRL_OFFSET: rdata_q <= {24'h000000, ctrl_view};
        RESTART_OFFSET: rdata_q <= '0;
        STATUS_OFFSET: rdata_q <= {10'h000, tif.count};
        default: begin
          rdata_q <= '0;
          rresp_q <= RESP_DECERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule : watchdog_timeout_control

// ### watchdog_timeout_control_chk.sv
// Port-level assertions of the watchdog timeout control block
`timescale 1ns/1ps
module watchdog_timeout_control_chk
  import watchdog_pkg::*;
#(
  parameter logic [21:0] TIMEOUT_BASE = TIMEOUT_BASE_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic watchdog_osc,
  input wire logic watchdog_reset_req,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [3:0] rd_addr_q;
  logic mapped;
  // ==========================================================================
  // Read address held so the answer can be judged by register
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_addr_q <= 4'h0;
    else if (s_axi_arvalid && s_axi_arready) rd_addr_q <= s_axi_araddr;
  end
  assign mapped = rd_addr_q inside {CTRL_OFFSET, RESTART_OFFSET, STATUS_OFFSET};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // Write handshake steps
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_write_answer;
    ##[1:3] s_axi_bvalid;
  endsequence
  property p_req_pulse;
    watchdog_reset_req |=> !watchdog_reset_req [*8];
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("reset request longer than one cycle");
  property p_rsvd_zero;
    s_axi_rvalid && rd_addr_q == CTRL_OFFSET |-> s_axi_rdata[31:5] == 27'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved control bits read non-zero");
  property p_wr_answer;
    s_write_taken |-> s_write_answer;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read data late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write taken during response");
  property p_unmapped;
    s_axi_rvalid && !mapped |-> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_mapped_ok;
    s_axi_rvalid && mapped |-> s_axi_rresp == RESP_OKAY;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped read refused");
endmodule : watchdog_timeout_control_chk

bind watchdog_timeout_control watchdog_timeout_control_chk #(
  .TIMEOUT_BASE(TIMEOUT_BASE)
) watchdog_timeout_control_chk_inst (
  .aclk(aclk), .aresetn(aresetn), .watchdog_osc(watchdog_osc),
  .watchdog_reset_req(watchdog_reset_req),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
